// ---- common/io_mode_pkg.sv ----
// Shared constants and types for the channel IO mode selector
package io_mode_pkg;

    // ****************************************
    // Run-time mode codes
    // ****************************************
    localparam logic [7:0] CODE_RESET_MODE = 8'h00;
    localparam logic [7:0] CODE_ASYNC_BB   = 8'h01;
    localparam logic [7:0] CODE_SYNC_SER   = 8'h02;
    localparam logic [7:0] CODE_SYNC_BB    = 8'h04;
    localparam logic [7:0] CODE_HOST_BUS   = 8'h08;
    localparam logic [7:0] CODE_OPTO       = 8'h10;

    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [3:0] OFS_MODE_A_CMD  = 4'h0;
    localparam logic [3:0] OFS_MODE_B_CMD  = 4'h1;
    localparam logic [3:0] OFS_NV_CFG      = 4'h2;
    localparam logic [3:0] OFS_STATUS      = 4'h3;
    localparam logic [3:0] OFS_BB_OUT      = 4'h4;
    localparam logic [3:0] OFS_BB_IN       = 4'h5;
    localparam logic [7:0] RST_NV_CFG      = 8'h00;
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam int         NV_B_POS        = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MAIN_UART     = 2'b00,
        MAIN_FIFO     = 2'b01,
        MAIN_CPU_FIFO = 2'b10,
        MAIN_OPTO     = 2'b11
    } main_mode_t;

    typedef enum logic [2:0] {
        ACT_MAIN     = 3'b000,
        ACT_ASYNC_BB = 3'b001,
        ACT_SYNC_SER = 3'b010,
        ACT_SYNC_BB  = 3'b011,
        ACT_HOST_BUS = 3'b100,
        ACT_OPTO_RST = 3'b101
    } act_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } pins8_t;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } pins4_t;

endpackage : io_mode_pkg

// ---- rtl/mode_decode.sv ----
// Per-channel run-time mode decoder
`timescale 1ns/1ps
`default_nettype none
module mode_decode (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_cmd_wr,
    input  wire logic [7:0]            i_cmd_code,
    input  wire logic                  i_is_chan_b,
    input  wire io_mode_pkg::main_mode_t i_main_mode,
    input  wire logic                  i_other_host_bus,
    output io_mode_pkg::act_mode_t     o_mode,
    output logic                       o_refused
);
    import io_mode_pkg::*;

    act_mode_t mode_q;
    act_mode_t mode_d;
    logic      ok;

    // ****************************************
    // Code decode
    // ****************************************
    always_comb begin
        mode_d = mode_q;
        ok     = 1'b1;
        case (i_cmd_code)
            CODE_RESET_MODE: mode_d = ACT_MAIN;
            CODE_ASYNC_BB,
            CODE_SYNC_BB: begin
                if (i_is_chan_b && i_main_mode == MAIN_OPTO) begin
                    ok = 1'b0;
                end else begin
                    mode_d = (i_cmd_code == CODE_ASYNC_BB) ? ACT_ASYNC_BB
                                                           : ACT_SYNC_BB;
                end
            end
            CODE_SYNC_SER: begin
                if (i_is_chan_b) begin
                    ok = 1'b0;
                end else begin
                    mode_d = ACT_SYNC_SER;
                end
            end
            CODE_HOST_BUS: mode_d = ACT_HOST_BUS;
            CODE_OPTO: begin
                if (i_main_mode == MAIN_OPTO) begin
                    mode_d = ACT_OPTO_RST;
                end else begin
                    ok = 1'b0;
                end
            end
            default: ok = 1'b0;
        endcase
        // Joint mode: while the other channel is in host bus mode, only code 0 is accepted here
        if (i_other_host_bus && i_cmd_code != CODE_RESET_MODE) begin
            ok     = 1'b0;
            mode_d = mode_q;
        end
        if (!ok) begin
            mode_d = mode_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            mode_q <= ACT_MAIN;
        end else if (i_cmd_wr) begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_refused <= 1'b0;
        end else if (i_cmd_wr) begin
            o_refused <= !ok;
        end
    end

    assign o_mode = mode_q;

endmodule : mode_decode
`default_nettype wire

// ---- rtl/io_mode_select.sv ----
// Dual-channel IO mode selection and channel B pin multiplexer
// Functional notes
// - Code 0 returns to the default mode, 1 selects async bit-bang, 2 the sync serial engine.
// - Code 4 is sync bit-bang, 8 is host bus emulation, 10 hex is the opto serial mode.
// - Code 10 holds the opto mode in reset until code 0 is written; the code also releases it on code 8, and on channel A on codes 1, 2 and 4.
// - Main modes come from nonvolatile setup; the others only from the mode command.
// - The sync serial engine lives only on channel A; B only lends address and strobes.
// - Host bus emulation occupies both channels together.
// - Channel A may run another mode while only channel B is in opto mode.
// - With both channels in opto mode all link signals sit on channel B pins.
// - Bit-bang is refused on channel B when its main mode is opto.
// - Bit-bang with FIFO or CPU FIFO main mode puts write on ctrl 0 and read on ctrl 1.
// - Bit-bang with UART main mode puts write on ctrl 2 and read on ctrl 3.
// - Send-now/wake is off in serial engine, host bus and CPU FIFO modes, else active; the code keeps it active in serial engine mode.
// - A missing or blank setup defaults both channels to UART.
// - A low strobe on send-now/wake asks resume in suspend, else flushes receive data; the code asks resume only in suspend with remote wake enabled.
// - Sync bit-bang samples the pins only when it writes them.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module io_mode_select (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire io_mode_pkg::reg_req_t i_req,
    output logic [7:0]                 o_rdata,
    input  wire logic                  i_nv_present,
    input  wire logic [7:0]            i_nv_cfg,
    input  wire logic                  i_suspend,
    input  wire logic                  i_remote_wake_en,
    output logic                       o_resume_req,
    output logic                       o_flush_rx,
    input  wire logic [7:0]            i_data_pins,
    output io_mode_pkg::pins8_t        o_data_pins,
    input  wire logic [3:0]            i_ctrl_pins,
    output io_mode_pkg::pins4_t        o_ctrl_pins,
    input  wire logic                  i_send_now_wake_b,
    input  wire logic [7:0]            i_fn_data,
    input  wire logic [7:0]            i_fn_data_oe,
    input  wire logic [3:0]            i_fn_ctrl,
    input  wire logic [3:0]            i_fn_ctrl_oe,
    input  wire logic [7:0]            i_eng_addr_hi,
    input  wire logic [3:0]            i_eng_strobes,
    input  wire logic [3:0]            i_opto_link_o,
    input  wire logic [3:0]            i_opto_link_oe,
    output logic [7:0]                 o_fn_data_in,
    output logic [3:0]                 o_fn_ctrl_in,
    output logic                       o_opto_a_rst,
    output logic                       o_opto_b_rst
);
    import io_mode_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] data_s1_q, data_s2_q;
    logic [3:0] ctrl_s1_q, ctrl_s2_q;
    logic       wake_s1_q, wake_s2_q, wake_s3_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            data_s1_q <= RST_BYTE;
            data_s2_q <= RST_BYTE;
            ctrl_s1_q <= 4'hF;
            ctrl_s2_q <= 4'hF;
            wake_s1_q <= 1'b1;
            wake_s2_q <= 1'b1;
            wake_s3_q <= 1'b1;
        end else begin
            data_s1_q <= i_data_pins;
            data_s2_q <= data_s1_q;
            ctrl_s1_q <= i_ctrl_pins;
            ctrl_s2_q <= ctrl_s1_q;
            wake_s1_q <= i_send_now_wake_b;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // ****************************************
    // Nonvolatile main modes
    // ****************************************
    logic [7:0] nv_q;
    main_mode_t main_a, main_b;

    // Loaded by a write to OFS_NV_CFG; a missing store reads as UART on both
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            nv_q <= RST_NV_CFG;
        end else if (i_req.wr && i_req.addr == OFS_NV_CFG) begin
            nv_q <= i_nv_present ? i_req.wdata : RST_NV_CFG;
        end
    end

    assign main_a = main_mode_t'(nv_q[1:0]);
    assign main_b = main_mode_t'(nv_q[NV_B_POS+1:NV_B_POS]);

    // ****************************************
    // Mode decoders
    // ****************************************
    act_mode_t mode_a, mode_b;
    logic      ref_a, ref_b;

    mode_decode u_dec_a (
        .i_clk            (i_clk),
        .i_rst_b          (i_rst_b),
        .i_cmd_wr         (i_req.wr && i_req.addr == OFS_MODE_A_CMD),
        .i_cmd_code       (i_req.wdata),
        .i_is_chan_b      (1'b0),
        .i_main_mode      (main_a),
        .i_other_host_bus (mode_b == ACT_HOST_BUS),
        .o_mode           (mode_a),
        .o_refused        (ref_a)
    );

    mode_decode u_dec_b (
        .i_clk            (i_clk),
        .i_rst_b          (i_rst_b),
        .i_cmd_wr         (i_req.wr && i_req.addr == OFS_MODE_B_CMD),
        .i_cmd_code       (i_req.wdata),
        .i_is_chan_b      (1'b1),
        .i_main_mode      (main_b),
        .i_other_host_bus (mode_a == ACT_HOST_BUS),
        .o_mode           (mode_b),
        .o_refused        (ref_b)
    );

    logic host_bus, b_bitbang, b_sync_bb, both_opto;

    assign host_bus  = (mode_a == ACT_HOST_BUS) || (mode_b == ACT_HOST_BUS);
    assign b_bitbang = (mode_b == ACT_ASYNC_BB) || (mode_b == ACT_SYNC_BB);
    assign b_sync_bb = (mode_b == ACT_SYNC_BB);
    assign both_opto = (main_a == MAIN_OPTO) && (main_b == MAIN_OPTO);

    assign o_opto_a_rst = (mode_a == ACT_OPTO_RST);
    assign o_opto_b_rst = (mode_b == ACT_OPTO_RST);

    // ****************************************
    // Bit-bang port and strobes
    // ****************************************
    logic [7:0] bb_out_q, bb_in_q;
    logic       bb_wr_q, bb_rd_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bb_out_q <= RST_BYTE;
            bb_wr_q  <= 1'b0;
        end else begin
            bb_wr_q <= i_req.wr && i_req.addr == OFS_BB_OUT && b_bitbang;
            if (i_req.wr && i_req.addr == OFS_BB_OUT) begin
                bb_out_q <= i_req.wdata;
            end
        end
    end

    // Sync mode reads only alongside a write, so bytes pair one to one
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bb_in_q <= RST_BYTE;
            bb_rd_q <= 1'b0;
        end else begin
            bb_rd_q <= b_sync_bb ? (i_req.wr && i_req.addr == OFS_BB_OUT)
                                 : (i_req.rd && i_req.addr == OFS_BB_IN);
            if (b_sync_bb) begin
                if (i_req.wr && i_req.addr == OFS_BB_OUT) begin
                    bb_in_q <= data_s2_q;
                end
            end else if (mode_b == ACT_ASYNC_BB) begin
                bb_in_q <= data_s2_q;
            end
        end
    end

    // ****************************************
    // Channel B pin routing
    // ****************************************
    always_comb begin
        o_data_pins.o  = i_fn_data;
        o_data_pins.oe = i_fn_data_oe;
        o_ctrl_pins.o  = i_fn_ctrl;
        o_ctrl_pins.oe = i_fn_ctrl_oe;
        if (host_bus) begin
            o_data_pins.o  = {3'h0, 1'b0, i_opto_link_o};
            o_data_pins.oe = {3'h0, 1'b0, i_opto_link_oe};
            o_ctrl_pins.o  = i_eng_strobes;
            o_ctrl_pins.oe = 4'hF;
        end else if (mode_a == ACT_SYNC_SER) begin
            o_data_pins.o  = i_eng_addr_hi;
            o_data_pins.oe = 8'hFF;
            o_ctrl_pins.o  = i_eng_strobes;
            o_ctrl_pins.oe = 4'hF;
        end else if (b_bitbang) begin
            o_data_pins.o  = bb_out_q;
            o_data_pins.oe = 8'hFF;
            o_ctrl_pins.oe = 4'hF;
            // Strobes are active low
            if (main_b == MAIN_UART) begin
                o_ctrl_pins.o = {!bb_rd_q, !bb_wr_q, 2'b11};
            end else begin
                o_ctrl_pins.o = {2'b11, !bb_rd_q, !bb_wr_q};
            end
        end else if (both_opto) begin
            o_data_pins.o  = {4'h0, i_opto_link_o};
            o_data_pins.oe = {4'h0, i_opto_link_oe};
            o_ctrl_pins.oe = 4'h0;
        end
    end

    assign o_fn_data_in = data_s2_q;
    assign o_fn_ctrl_in = ctrl_s2_q;

    // ****************************************
    // Send-now / wake
    // ****************************************
    logic wake_en, wake_fall;

    assign wake_en = !(host_bus || mode_b == ACT_SYNC_SER
                       || (mode_b == ACT_MAIN && main_b == MAIN_CPU_FIFO));
    assign wake_fall = wake_s3_q && !wake_s2_q && wake_en;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_resume_req <= 1'b0;
            o_flush_rx   <= 1'b0;
        end else begin
            o_resume_req <= wake_fall && i_suspend && i_remote_wake_en;
            o_flush_rx   <= wake_fall && !(i_suspend && i_remote_wake_en);
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rdata <= RST_BYTE;
        end else if (i_req.rd) begin
            case (i_req.addr)
                OFS_NV_CFG:     o_rdata <= nv_q;
                OFS_STATUS:     o_rdata <= {ref_b, mode_b, ref_a, mode_a};
                OFS_BB_OUT:     o_rdata <= bb_out_q;
                OFS_BB_IN:      o_rdata <= bb_in_q;
                default:        o_rdata <= RST_BYTE;
            endcase
        end else begin
            o_rdata <= RST_BYTE;
        end
    end

endmodule : io_mode_select
`default_nettype wire

// ---- tb/io_mode_select_sva.sv ----
// Port checker for the channel IO mode selector
`timescale 1ns/1ps
`default_nettype none
module io_mode_select_chk
    import io_mode_pkg::*;
(
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire io_mode_pkg::reg_req_t i_req,
    input wire logic [7:0]            o_rdata,
    input wire logic                  i_suspend,
    input wire logic                  i_remote_wake_en,
    input wire logic                  o_resume_req,
    input wire logic                  o_flush_rx,
    input wire logic                  o_opto_a_rst,
    input wire logic                  o_opto_b_rst
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic       wr_a_q;
    logic       wr_b_q;
    logic [7:0] code_q;
    // Previous cycle's command write flags and write data kept, so a rising reset flag traces to its cause
    always_ff @(posedge i_clk) begin
        wr_a_q <= i_rst_b && i_req.wr && i_req.addr == OFS_MODE_A_CMD;
        wr_b_q <= i_rst_b && i_req.wr && i_req.addr == OFS_MODE_B_CMD;
        code_q <= i_req.wdata;
    end
    sequence s_cmd(logic [3:0] a, logic [7:0] c);
        i_req.wr && i_req.addr == a && i_req.wdata == c;
    endsequence
    sequence s_pulse;
        o_flush_rx || o_resume_req;
    endsequence
    property p_opto_b_set;
        $rose(o_opto_b_rst) |-> wr_b_q && code_q == CODE_OPTO;
    endproperty
    property p_opto_b_rel;
        s_cmd(OFS_MODE_B_CMD, CODE_RESET_MODE) |=> !o_opto_b_rst;
    endproperty
    property p_opto_a_set;
        $rose(o_opto_a_rst) |-> wr_a_q && code_q == CODE_OPTO;
    endproperty
    property p_opto_a_rel;
        s_cmd(OFS_MODE_A_CMD, CODE_RESET_MODE) |=> !o_opto_a_rst;
    endproperty
    property p_rdata_idle;
        !i_req.rd |=> o_rdata == RST_BYTE;
    endproperty
    property p_resume_cond;
        o_resume_req |-> $past(i_suspend && i_remote_wake_en);
    endproperty
    property p_flush_cond;
        o_flush_rx |-> !$past(i_suspend && i_remote_wake_en);
    endproperty
    property p_pulse_one;
        s_pulse |=> !o_flush_rx && !o_resume_req;
    endproperty
    a_opto_b_set: assert property (p_opto_b_set) else $error("opto B reset rose uncommanded");
    a_opto_b_rel: assert property (p_opto_b_rel) else $error("opto B reset not released");
    a_opto_a_set: assert property (p_opto_a_set) else $error("opto A reset rose uncommanded");
    a_opto_a_rel: assert property (p_opto_a_rel) else $error("opto A reset not released");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_resume_cond: assert property (p_resume_cond) else $error("resume outside suspend");
    a_flush_cond: assert property (p_flush_cond) else $error("flush during suspend wake");
    a_pulse_one: assert property (p_pulse_one) else $error("wake pulse too long");
endmodule : io_mode_select_chk
bind io_mode_select io_mode_select_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .o_rdata(o_rdata), .i_suspend(i_suspend), .i_remote_wake_en(i_remote_wake_en),
    .o_resume_req(o_resume_req), .o_flush_rx(o_flush_rx), .o_opto_a_rst(o_opto_a_rst),
    .o_opto_b_rst(o_opto_b_rst));
`default_nettype wire

// ---- tb/pin_peer.sv ----
// Peripheral logic model on the channel B pins
`timescale 1ns/1ps
`default_nettype none
module pin_peer (
    input  wire logic                 i_clk,
    input  wire io_mode_pkg::pins8_t  i_data_drv,
    input  wire io_mode_pkg::pins4_t  i_ctrl_drv,
    input  wire logic                 i_wake_go,
    output logic [7:0]                o_data_lvl,
    output logic [3:0]                o_ctrl_lvl,
    output logic                      o_wake_b
);
    import io_mode_pkg::*;
    logic [7:0] idle_q = 8'h5A;
    logic [1:0] low_q  = 2'h0;
    // Released data bits walk, so a stale value never passes
    always_ff @(posedge i_clk) idle_q <= {idle_q[6:0], idle_q[7]};
    always_ff @(posedge i_clk) begin
        if (i_wake_go) begin
            low_q <= 2'h2;
        end else if (low_q != 2'h0) begin
            low_q <= low_q - 2'h1;
        end
    end
    assign o_data_lvl = (i_data_drv.o & i_data_drv.oe) | (idle_q & ~i_data_drv.oe);
    // Control lines have pull-ups
    assign o_ctrl_lvl = (i_ctrl_drv.o & i_ctrl_drv.oe) | ~i_ctrl_drv.oe;
    assign o_wake_b   = (low_q == 2'h0);
endmodule : pin_peer
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the channel IO mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import io_mode_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, nv_present = 1'b1, suspend = 1'b0, rwe = 1'b0;
    logic       wake_go = 1'b0, wake_b, resume, flush, opto_a, opto_b;
    logic [7:0] fn8 = 8'h3C, rdata, dlvl, v, fdin;
    logic [3:0] fn4 = 4'h6, clvl, fcin;
    logic [7:0] codes [5] = '{CODE_RESET_MODE, CODE_ASYNC_BB, CODE_SYNC_SER, CODE_SYNC_BB,
                              CODE_HOST_BUS};
    reg_req_t   req = '0;
    pins8_t     dpins;
    pins4_t     cpins;
    int         n_mismatch = 0, checks = 0, i;
    always #10 clk = ~clk;
    io_mode_select uut (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rdata(rdata),
        .i_nv_present(nv_present), .i_nv_cfg(fn8), .i_suspend(suspend),
        .i_remote_wake_en(rwe), .o_resume_req(resume), .o_flush_rx(flush),
        .i_data_pins(dlvl), .o_data_pins(dpins), .i_ctrl_pins(clvl), .o_ctrl_pins(cpins),
        .i_send_now_wake_b(wake_b), .i_fn_data(fn8), .i_fn_data_oe(fn8), .i_fn_ctrl(fn4),
        .i_fn_ctrl_oe(fn4), .i_eng_addr_hi(fn8), .i_eng_strobes(fn4), .i_opto_link_o(fn4),
        .i_opto_link_oe(fn4), .o_fn_data_in(fdin), .o_fn_ctrl_in(fcin), .o_opto_a_rst(opto_a),
        .o_opto_b_rst(opto_b));
    pin_peer peer (.i_clk(clk), .i_data_drv(dpins), .i_ctrl_drv(cpins), .i_wake_go(wake_go),
        .o_data_lvl(dlvl), .o_ctrl_lvl(clvl), .o_wake_b(wake_b));
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic st(input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] s;
        rd(OFS_STATUS, s);
        chk(s & mask, exp);
    endtask : st
    // Read strobe rides with the write in sync mode, with the read otherwise
    task automatic bb(input logic [1:0] line, input logic [7:0] ein, input logic sync);
        logic [7:0] s;
        wr(OFS_BB_OUT, 8'h5A);
        #1 chk({7'h0, cpins.o[line]}, 8'h00);
        chk({7'h0, cpins.o[line+2'h1]}, {7'h0, !sync});
        chk({7'h0, cpins.oe[line]}, 8'h01);
        chk(dpins.o, 8'h5A);
        rd(OFS_BB_IN, s);
        chk(s, ein);
        chk({7'h0, cpins.o[line+2'h1]}, {7'h0, sync});
        chk(fdin, 8'h5A);
    endtask : bb
    // Fixed watch window, since the pulse latency is the design's choice
    task automatic wake(input logic ef, input logic er);
        logic f;
        logic r;
        f = 1'b0;
        r = 1'b0;
        @(posedge clk) wake_go <= 1'b1;
        @(posedge clk) wake_go <= 1'b0;
        repeat (12) begin
            @(posedge clk) #1;
            f = f | flush;
            r = r | resume;
        end
        chk({7'h0, f}, {7'h0, ef});
        chk({7'h0, r}, {7'h0, er});
    endtask : wake
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFS_NV_CFG, v);
        chk(v, RST_NV_CFG);
        st(8'hFF, 8'h00);
        $display("test reset done");
        for (i = 0; i < 5; i++) begin
            wr(OFS_MODE_A_CMD, codes[i]);
            st(8'h0F, i[7:0]);
        end
        wr(OFS_MODE_B_CMD, CODE_ASYNC_BB);
        st(8'h80, 8'h80);
        chk({4'h0, fcin}, 8'h06);
        wr(OFS_MODE_A_CMD, CODE_RESET_MODE);
        wr(OFS_MODE_B_CMD, CODE_RESET_MODE);
        wr(OFS_MODE_B_CMD, CODE_SYNC_SER);
        st(8'hF0, 8'h80);
        wr(OFS_MODE_B_CMD, 8'h03);
        st(8'hF0, 8'h80);
        wr(OFS_MODE_A_CMD, CODE_OPTO);
        st(8'h0F, 8'h08);
        chk({7'h0, opto_a}, 8'h00);
        $display("test codes done");
        @(posedge clk) nv_present <= 1'b0;
        wr(OFS_NV_CFG, 8'h11);
        wr(OFS_MODE_B_CMD, CODE_SYNC_BB);
        st(8'hF0, 8'h30);
        bb(2'h2, 8'h00, 1'b1);
        @(posedge clk) nv_present <= 1'b1;
        wr(OFS_NV_CFG, 8'h10);
        rd(OFS_NV_CFG, v);
        chk(v, 8'h10);
        bb(2'h0, 8'h5A, 1'b1);
        wr(OFS_MODE_B_CMD, CODE_ASYNC_BB);
        bb(2'h0, 8'h5A, 1'b0);
        $display("test strobes done");
        wake(1'b1, 1'b0);
        @(posedge clk) begin
            suspend <= 1'b1;
            rwe <= 1'b1;
        end
        wake(1'b0, 1'b1);
        @(posedge clk) suspend <= 1'b0;
        wr(OFS_NV_CFG, 8'h20);
        wr(OFS_MODE_B_CMD, CODE_RESET_MODE);
        wake(1'b0, 1'b0);
        $display("test wake done");
        wr(OFS_NV_CFG, 8'h30);
        wr(OFS_MODE_B_CMD, CODE_SYNC_BB);
        st(8'hF0, 8'h80);
        wr(OFS_MODE_B_CMD, CODE_OPTO);
        st(8'hF0, 8'h50);
        chk({7'h0, opto_b}, 8'h01);
        wr(OFS_MODE_A_CMD, CODE_ASYNC_BB);
        st(8'hFF, 8'h51);
        wake(1'b1, 1'b0);
        wr(OFS_MODE_B_CMD, CODE_RESET_MODE);
        #1 chk({7'h0, opto_b}, 8'h00);
        wr(OFS_NV_CFG, 8'h33);
        #1 chk(dpins.o, 8'h06);
        chk(dpins.oe, 8'h06);
        chk({4'h0, cpins.oe}, 8'h00);
        $display("test opto done");
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        st(8'hFF, 8'h00);
        rd(OFS_NV_CFG, v);
        chk(v, RST_NV_CFG);
        $display("test rerun reset done");
        summarize();
    end
    // Hang guard
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
